// File: rtl/sac_pkg.sv
// ==========================================================
// converter control constants
// ==========================================================
package sac_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] SAC_IDX_CTRL_B = 8'h03;
   localparam logic [7:0] SAC_IDX_RES_LO = 8'h04;
   localparam logic [7:0] SAC_IDX_RES_HI = 8'h05;
   localparam logic [7:0] SAC_IDX_CTRL_A = 8'h06;
   localparam logic [7:0] SAC_IDX_CHREF = 8'h07;
   localparam logic [7:0] SAC_IDX_PIN_DIS = 8'h0d;
   localparam logic [7:0] SAC_IDX_PWR = 8'h0e;

   // converter_control_a fields
   localparam int SAC_CA_EN = 7;
   localparam int SAC_CA_SC = 6;
   localparam int SAC_CA_ATE = 5;
   localparam int SAC_CA_IF = 4;
   localparam int SAC_CA_IE = 3;
   localparam int SAC_CA_PS_LSB = 0;
   // converter_control_b fields
   localparam int SAC_CB_LAR = 7;
   localparam int SAC_CB_ME = 6;
   localparam int SAC_CB_TS_LSB = 0;
   // channel_reference_register fields
   localparam int SAC_CR_REF = 6;
   localparam int SAC_CR_MUX_LSB = 0;
   // power_reduction_register field
   localparam int SAC_PWR_BIT = 0;

   // reset values
   localparam logic [7:0] SAC_RST_CTRL_A = 8'h00;
   localparam logic [7:0] SAC_RST_CTRL_B = 8'h00;
   localparam logic [7:0] SAC_RST_CHREF = 8'h00;
   localparam logic [7:0] SAC_RST_PIN_DIS = 8'h00;
   localparam logic SAC_RST_PWR = 1'b0;

   // conversion lengths in converter clock cycles
   localparam logic [4:0] SAC_LEN_NORMAL = 5'd13;
   localparam logic [4:0] SAC_LEN_FIRST = 5'd25;

   // trigger select value that means completion flag as source
   localparam logic [2:0] SAC_TS_FREE_RUN = 3'h0;

   typedef enum logic [1:0] {SAC_ST_IDLE, SAC_ST_WAIT, SAC_ST_CONV} sac_state_type;

endpackage : sac_pkg

// File: rtl/sac_sync.sv
`timescale 1ns/1ps
// ==========================================================
// two-stage synchroniser for a vector of levels
// ==========================================================
module sac_sync #(
   parameter int W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q_r
);
   logic [W-1:0] meta_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
endmodule : sac_sync

// File: rtl/sac_prescaler.sv
`timescale 1ns/1ps
// ==========================================================
// converter clock prescaler, one tick per converter clock
// ==========================================================
module sac_prescaler
   import sac_pkg::*;
#(
   parameter int W = 7
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clear,
   input wire logic [2:0] div_sel,
   output logic tick_r
);
   logic [W-1:0] count_r;

   // division 2,2,4,8,...,128; returns divisor minus one
   function automatic logic [W-1:0] last_count(input logic [2:0] sel);
      logic [W:0] div;
      div = (sel == 3'h0) ? (W+1)'(2) : (W+1)'(1) << sel;
      return W'(div - (W+1)'(1));
   endfunction : last_count

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= '0;
         tick_r <= 1'b0;
      end else if (clear) begin
         count_r <= '0;
         tick_r <= 1'b0;
      end else if (count_r >= last_count(div_sel)) begin
         count_r <= '0;
         tick_r <= 1'b1;
      end else begin
         count_r <= count_r + W'(1);
         tick_r <= 1'b0;
      end
   end
endmodule : sac_prescaler

// File: rtl/sac_top.sv
`timescale 1ns/1ps
module sac_top
   import sac_pkg::*;
#(
   parameter int NTRIG = 8,
   parameter int NPIN = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NTRIG-1:0] trig_src,
   input wire logic [NPIN-1:0] pin_in,
   input wire logic [9:0] ana_code,
   output logic ana_enable,
   output logic ana_reference,
   output logic [3:0] ana_channel,
   output logic ana_sample,
   output logic ana_conv_tick,
   output logic comp_neg_mux_sel,
   output logic [2:0] comp_mux_channel,
   output logic [NPIN-1:0] pin_buf_disable,
   output logic [NPIN-1:0] pin_read,
   output logic done_irq
);

   // ==========================================================
   // declarations
   // ==========================================================
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   logic wr_pend_r;
   logic rd_pend_r;
   logic [7:0] idx_r;
   logic [7:0] ctrl_a_r;
   logic [7:0] ctrl_b_r;
   logic [7:0] chref_r;
   logic [NPIN-1:0] pin_dis_r;
   logic pwr_red_r;
   logic [9:0] result_r;
   logic lock_r;
   logic flag_r;
   logic done_irq_r;
   logic [3:0] chan_act_r;
   logic ref_act_r;
   logic ana_enable_r;
   logic ana_sample_r;
   logic comp_neg_mux_sel_r;
   logic [NPIN-1:0] pin_read_r;
   sac_state_type state_r;
   logic [4:0] cnt_r;
   logic first_r;
   logic len_first_r;
   logic trig_prev_r;
   logic [NTRIG-1:0] trig_s;
   logic [NPIN-1:0] pin_s;
   logic [9:0] code_s;
   logic tick;
   logic accept;
   logic [7:0] wd;
   logic wr_ctrl_a;
   logic conv_on;
   logic sc_wr;
   logic trig_sel;
   logic trig_edge;
   logic trig_go;
   logic [4:0] len;
   logic done;
   logic free_next;
   logic start_now;
   logic presc_clear;
   logic rd_lo;
   logic rd_hi;
   logic [7:0] rd_val;

   // result byte view, high byte when hi is set
   function automatic logic [7:0] res_byte(input logic [9:0] r, input logic left, input logic hi);
      logic [15:0] w;
      w = left ? {r, 6'h00} : {6'h00, r};
      return hi ? w[15:8] : w[7:0];
   endfunction : res_byte

   // ==========================================================
   // input synchronisers
   // ==========================================================
   sac_sync #(.W(NTRIG)) u_trig_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(trig_src),
      .q_r(trig_s)
   );

   sac_sync #(.W(NPIN)) u_pin_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(pin_in),
      .q_r(pin_s)
   );

   // core holds its code stable once a conversion ends
   sac_sync #(.W(10)) u_code_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(ana_code),
      .q_r(code_s)
   );

   // ==========================================================
   // converter clock
   // ==========================================================
   sac_prescaler u_presc (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(presc_clear),
      .div_sel(ctrl_a_r[SAC_CA_PS_LSB +: 3]),
      .tick_r(tick)
   );

   // ==========================================================
   // control terms
   // ==========================================================
   always_comb begin
      accept = hsel && hready && htrans[1];
      wd = hwdata[7:0];
      wr_ctrl_a = wr_pend_r && (idx_r == SAC_IDX_CTRL_A);
      conv_on = ctrl_a_r[SAC_CA_EN] && !pwr_red_r;
      sc_wr = wr_ctrl_a && wd[SAC_CA_SC];
      trig_sel = trig_s[ctrl_b_r[SAC_CB_TS_LSB +: 3]];
      trig_edge = trig_sel && !trig_prev_r;
      trig_go = conv_on && ctrl_a_r[SAC_CA_ATE]
         && (ctrl_b_r[SAC_CB_TS_LSB +: 3] != SAC_TS_FREE_RUN)
         && trig_edge && (state_r != SAC_ST_CONV);
      len = len_first_r ? SAC_LEN_FIRST : SAC_LEN_NORMAL;
      done = conv_on && (state_r == SAC_ST_CONV) && tick && (cnt_r == len - 5'd1);
      free_next = done && ctrl_a_r[SAC_CA_ATE]
         && (ctrl_b_r[SAC_CB_TS_LSB +: 3] == SAC_TS_FREE_RUN);
      start_now = trig_go || ((state_r == SAC_ST_WAIT) && tick) || free_next;
      presc_clear = !conv_on || trig_go;
      rd_lo = rd_pend_r && (idx_r == SAC_IDX_RES_LO);
      rd_hi = rd_pend_r && (idx_r == SAC_IDX_RES_HI);
   end

   // ==========================================================
   // bus slave
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         idx_r <= 8'h00;
         hreadyout_r <= 1'b1;
      end else begin
         wr_pend_r <= accept && hwrite;
         rd_pend_r <= accept && !hwrite;
         if (accept) begin
            idx_r <= haddr[9:2];
         end
         // reads take one wait state so a preceding write is seen
         hreadyout_r <= !(accept && !hwrite);
      end
   end

   always_comb begin
      case (idx_r)
         SAC_IDX_CTRL_A: begin
            rd_val = ctrl_a_r;
            rd_val[SAC_CA_SC] = (state_r != SAC_ST_IDLE);
            rd_val[SAC_CA_IF] = flag_r;
         end
         SAC_IDX_CTRL_B: rd_val = ctrl_b_r;
         SAC_IDX_CHREF: rd_val = chref_r;
         SAC_IDX_RES_LO: rd_val = res_byte(result_r, ctrl_b_r[SAC_CB_LAR], 1'b0);
         SAC_IDX_RES_HI: rd_val = res_byte(result_r, ctrl_b_r[SAC_CB_LAR], 1'b1);
         SAC_IDX_PIN_DIS: rd_val = pin_dis_r;
         SAC_IDX_PWR: rd_val = {7'h00, pwr_red_r};
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
         hresp_r <= 1'b0;
      end else begin
         hresp_r <= 1'b0;
         if (rd_pend_r) begin
            hrdata_r <= {24'h00_0000, rd_val};
         end
      end
   end

   // ==========================================================
   // software registers
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_a_r <= SAC_RST_CTRL_A;
      end else if (wr_ctrl_a) begin
         // start and flag bits are kept elsewhere
         ctrl_a_r <= wd & ~(8'h01 << SAC_CA_SC) & ~(8'h01 << SAC_CA_IF);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_b_r <= SAC_RST_CTRL_B;
         chref_r <= SAC_RST_CHREF;
         pin_dis_r <= SAC_RST_PIN_DIS[NPIN-1:0];
         pwr_red_r <= SAC_RST_PWR;
      end else if (wr_pend_r) begin
         case (idx_r)
            SAC_IDX_CTRL_B: ctrl_b_r <= wd & 8'hc7;
            SAC_IDX_CHREF: chref_r <= wd & 8'h4f;
            SAC_IDX_PIN_DIS: pin_dis_r <= wd[NPIN-1:0];
            SAC_IDX_PWR: pwr_red_r <= wd[SAC_PWR_BIT];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // conversion sequencer
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= SAC_ST_IDLE;
         cnt_r <= 5'd0;
      end else if (!conv_on) begin
         state_r <= SAC_ST_IDLE;
         cnt_r <= 5'd0;
      end else begin
         case (state_r)
            SAC_ST_IDLE: begin
               if (trig_go) begin
                  state_r <= SAC_ST_CONV;
                  cnt_r <= 5'd0;
               end else if (sc_wr) begin
                  state_r <= SAC_ST_WAIT;
               end
            end
            SAC_ST_WAIT: begin
               if (start_now) begin
                  state_r <= SAC_ST_CONV;
                  cnt_r <= 5'd0;
               end
            end
            SAC_ST_CONV: begin
               if (done) begin
                  cnt_r <= 5'd0;
                  state_r <= free_next ? SAC_ST_CONV : SAC_ST_IDLE;
               end else if (tick) begin
                  cnt_r <= cnt_r + 5'd1;
               end
            end
            default: state_r <= SAC_ST_IDLE;
         endcase
      end
   end

   // first conversion after enabling runs long
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_r <= 1'b1;
         len_first_r <= 1'b0;
      end else if (!conv_on) begin
         first_r <= 1'b1;
      end else if (start_now) begin
         len_first_r <= first_r;
         first_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_prev_r <= 1'b0;
      end else begin
         trig_prev_r <= trig_sel;
      end
   end

   // ==========================================================
   // result, lock and completion flag
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_r <= 10'h000;
      end else if (done && !lock_r) begin
         result_r <= code_s;
      end
   end

   // high-byte read releases; software reads low first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_r <= 1'b0;
      end else if (rd_lo) begin
         lock_r <= 1'b1;
      end else if (rd_hi) begin
         lock_r <= 1'b0;
      end
   end

   // set wins over a same-cycle clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= 1'b0;
         done_irq_r <= 1'b0;
      end else begin
         if (done) begin
            flag_r <= 1'b1;
         end else if (wr_ctrl_a && wd[SAC_CA_IF]) begin
            flag_r <= 1'b0;
         end
         done_irq_r <= flag_r && ctrl_a_r[SAC_CA_IE];
      end
   end

   // ==========================================================
   // analog core and pin controls
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan_act_r <= 4'h0;
         ref_act_r <= 1'b0;
      end else if (conv_on && ((state_r != SAC_ST_CONV) || done)) begin
         chan_act_r <= chref_r[SAC_CR_MUX_LSB +: 4];
         ref_act_r <= chref_r[SAC_CR_REF];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ana_enable_r <= 1'b0;
         ana_sample_r <= 1'b0;
         comp_neg_mux_sel_r <= 1'b0;
         pin_read_r <= '0;
      end else begin
         ana_enable_r <= conv_on;
         ana_sample_r <= start_now;
         comp_neg_mux_sel_r <= ctrl_b_r[SAC_CB_ME] && !conv_on;
         pin_read_r <= pin_s & ~pin_dis_r;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign ana_enable = ana_enable_r;
   assign ana_reference = ref_act_r;
   assign ana_channel = chan_act_r;
   assign ana_sample = ana_sample_r;
   assign ana_conv_tick = tick;
   assign comp_neg_mux_sel = comp_neg_mux_sel_r;
   assign comp_mux_channel = chref_r[SAC_CR_MUX_LSB +: 3];
   assign pin_buf_disable = pin_dis_r;
   assign pin_read = pin_read_r;
   assign done_irq = done_irq_r;

   // ==========================================================
   // assertions
   // ==========================================================
   AST_PWR_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
      pwr_red_r |=> (state_r == SAC_ST_IDLE))
      else $error("converter active while power reduced");

   AST_LOCK_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      (done && lock_r) |=> $stable(result_r))
      else $error("result changed while locked");

   AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      done |=> flag_r)
      else $error("done flag not set on completion");

   AST_SINGLE_END: assert property (@(posedge hclk) disable iff (!hresetn)
      (done && !free_next) |=> (state_r == SAC_ST_IDLE) && (rd_val[SAC_CA_SC] == 1'b0 || idx_r != SAC_IDX_CTRL_A))
      else $error("start bit not cleared at completion");

   AST_CHAN_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      ((state_r == SAC_ST_CONV) && $past(state_r == SAC_ST_CONV) && !$past(done)) |-> $stable(chan_act_r))
      else $error("channel changed during conversion");

   AST_TRIG_START: assert property (@(posedge hclk) disable iff (!hresetn)
      trig_go |=> (state_r == SAC_ST_CONV) && (cnt_r == 5'd0) && ana_sample_r && !tick)
      else $error("trigger edge did not start conversion");

   AST_EDGE_IGNORED: assert property (@(posedge hclk) disable iff (!hresetn)
      (conv_on && (state_r == SAC_ST_CONV) && (cnt_r != 5'd0) && !done && !tick) |=> (cnt_r == $past(cnt_r)))
      else $error("conversion restarted by trigger");

   AST_LENGTH: assert property (@(posedge hclk) disable iff (!hresetn)
      done |-> (cnt_r == (len_first_r ? 5'd24 : 5'd12)))
      else $error("conversion length wrong");

   AST_FREE_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
      free_next |=> (state_r == SAC_ST_CONV) && (cnt_r == 5'd0))
      else $error("free running did not restart");

   AST_PIN_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> ((pin_read_r & $past(pin_dis_r)) == '0))
      else $error("disabled pin reads one");

   AST_COMP_MUX: assert property (@(posedge hclk) disable iff (!hresetn)
      conv_on |=> !comp_neg_mux_sel_r)
      else $error("comparator mux selected while converter on");

   AST_PRESC_HELD: assert property (@(posedge hclk) disable iff (!hresetn)
      (!conv_on ##1 !conv_on) |-> !tick)
      else $error("prescaler ran while disabled");

endmodule : sac_top

// File: bench/sac_ana_model.sv
`timescale 1ns/1ps
// ==========================================================
// analog core model: sample on pulse, hold code until next while enabled, toggle every bit each cycle while disabled
// ==========================================================
module sac_ana_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ana_enable,
   input wire logic ana_reference,
   input wire logic [3:0] ana_channel,
   input wire logic ana_sample,
   output logic [9:0] ana_code
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ana_code <= 10'h000;
      end else if (!ana_enable) begin
         // powered down: code is meaningless
         ana_code <= ~ana_code;
      end else if (ana_sample) begin
         ana_code <= {ana_reference, ana_channel, 5'h15};
      end
   end
endmodule : sac_ana_model

// File: bench/tb.sv
`timescale 1ns/1ps
module tb
   import sac_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [7:0] trig_src, pin_in, pin_buf_disable, pin_read;
   logic [9:0] ana_code;
   logic ana_enable, ana_reference, ana_sample, ana_conv_tick, comp_neg_mux_sel, done_irq;
   logic [3:0] ana_channel;
   logic [2:0] comp_mux_channel;
   int bad_count, checked, cyc, t0, ticks;

   sac_top u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_src(trig_src),
      .pin_in(pin_in), .ana_code(ana_code), .ana_enable(ana_enable),
      .ana_reference(ana_reference), .ana_channel(ana_channel), .ana_sample(ana_sample),
      .ana_conv_tick(ana_conv_tick), .comp_neg_mux_sel(comp_neg_mux_sel),
      .comp_mux_channel(comp_mux_channel), .pin_buf_disable(pin_buf_disable),
      .pin_read(pin_read), .done_irq(done_irq)
   );

   sac_ana_model u_ana (
      .hclk(hclk), .hresetn(hresetn), .ana_enable(ana_enable), .ana_reference(ana_reference),
      .ana_channel(ana_channel), .ana_sample(ana_sample), .ana_code(ana_code)
   );

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (ana_conv_tick === 1'b1) begin
         ticks <= ticks + 1;
      end
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end

   // ==========================================================
   // bus tasks
   // ==========================================================
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
      xfer(1'b0, idx, 32'h0);
      chk(q, exp, msg);
   endtask : rd_chk

   task automatic pause(input int n);
      repeat (n) @(posedge hclk);
   endtask : pause

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         xfer(1'b0, SAC_IDX_CTRL_A, 32'h0);
         n++;
      end while (q[SAC_CA_SC] !== 1'b0 && n < 100);
      if (n >= 100) begin
         bad_count++;
         $display("[FAIL] %0t converter stayed busy", $time);
      end
   endtask : wait_idle

   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask : end_test

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // tests
   // ==========================================================
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      {trig_src, bad_count, checked, cyc, ticks} = '0;
      pin_in = 8'hff;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(SAC_IDX_CTRL_A, 32'h0, "ctrl_a reset");
      rd_chk(SAC_IDX_CTRL_B, 32'h0, "ctrl_b reset");
      rd_chk(SAC_IDX_PIN_DIS, 32'h0, "pin disable reset");
      wr(8'h3f, 32'hff);
      rd_chk(8'h3f, 32'h0, "unmapped");
      wr(SAC_IDX_PIN_DIS, 32'ha5);
      rd_chk(SAC_IDX_PIN_DIS, 32'ha5, "pin disable rw");
      pause(4);
      chk({24'h0, pin_read}, 32'h5a, "pin read");
      chk({24'h0, pin_buf_disable}, 32'ha5, "buffer off");
      end_test("registers");
      wr(SAC_IDX_PWR, 32'h1);
      wr(SAC_IDX_CHREF, 32'h45);
      pause(3);
      chk({28'h0, ana_channel}, 32'h0, "channel while off");
      wr(SAC_IDX_CTRL_A, 32'hc0);
      pause(60);
      rd_chk(SAC_IDX_CTRL_A, 32'h80, "start when power reduced");
      chk({31'h0, ana_enable}, 32'h0, "core off");
      wr(SAC_IDX_CTRL_A, 32'h00);
      wr(SAC_IDX_PWR, 32'h0);
      wr(SAC_IDX_CTRL_A, 32'h80);
      t0 = cyc;
      wr(SAC_IDX_CTRL_A, 32'hc0);
      rd_chk(SAC_IDX_CTRL_A, 32'hc0, "busy");
      chk({27'h0, ana_reference, ana_channel}, 32'h15, "selection applied");
      pause(30);
      rd_chk(SAC_IDX_CTRL_A, 32'hc0, "first still busy");
      wait_idle();
      chk(32'((cyc - t0 >= 50) && (cyc - t0 <= 66)), 32'h1, "first length");
      rd_chk(SAC_IDX_CTRL_A, 32'h90, "done");
      rd_chk(SAC_IDX_RES_LO, 32'hb5, "low");
      rd_chk(SAC_IDX_RES_HI, 32'h02, "high");
      end_test("single");
      t0 = cyc;
      wr(SAC_IDX_CTRL_A, 32'hd0);
      pause(6);
      wr(SAC_IDX_CHREF, 32'h43);
      pause(2);
      chk({28'h0, ana_channel}, 32'h5, "channel held");
      wait_idle();
      chk(32'((cyc - t0 >= 26) && (cyc - t0 <= 40)), 32'h1, "normal length");
      chk({28'h0, ana_channel}, 32'h3, "channel after end");
      rd_chk(SAC_IDX_RES_LO, 32'hb5, "old channel low");
      rd_chk(SAC_IDX_RES_HI, 32'h02, "old channel high");
      end_test("channel change");
      wr(SAC_IDX_CTRL_B, 32'h80);
      rd_chk(SAC_IDX_RES_LO, 32'h40, "left low");
      wr(SAC_IDX_CTRL_A, 32'hd0);
      wait_idle();
      rd_chk(SAC_IDX_CTRL_A, 32'h90, "flag while locked");
      rd_chk(SAC_IDX_RES_HI, 32'had, "locked high");
      wr(SAC_IDX_CTRL_B, 32'h00);
      wr(SAC_IDX_CTRL_A, 32'hd0);
      wait_idle();
      rd_chk(SAC_IDX_RES_LO, 32'h75, "unlocked low");
      rd_chk(SAC_IDX_RES_HI, 32'h02, "unlocked high");
      end_test("lock");
      wr(SAC_IDX_CTRL_B, 32'h01);
      wr(SAC_IDX_CTRL_A, 32'hb0);
      trig_src <= 8'h02;
      pause(12);
      rd_chk(SAC_IDX_CTRL_A, 32'he0, "triggered");
      trig_src <= 8'h00;
      pause(2);
      trig_src <= 8'h02;
      wait_idle();
      pause(10);
      rd_chk(SAC_IDX_CTRL_A, 32'hb0, "no retrigger");
      trig_src <= 8'h00;
      pause(4);
      trig_src <= 8'h02;
      pause(8);
      rd_chk(SAC_IDX_CTRL_A, 32'hf0, "retrigger");
      wait_idle();
      end_test("auto trigger");
      trig_src <= 8'h00;
      wr(SAC_IDX_CTRL_B, 32'h00);
      wr(SAC_IDX_CTRL_A, 32'hf0);
      pause(80);
      rd_chk(SAC_IDX_CTRL_A, 32'hf0, "free running");
      wr(SAC_IDX_CTRL_A, 32'hb0);
      pause(40);
      rd_chk(SAC_IDX_CTRL_A, 32'hf0, "runs after clear");
      wr(SAC_IDX_CTRL_A, 32'h90);
      wait_idle();
      rd_chk(SAC_IDX_CTRL_A, 32'h90, "stopped");
      wr(SAC_IDX_CTRL_A, 32'h88);
      pause(3);
      chk({31'h0, done_irq}, 32'h1, "irq level");
      wr(SAC_IDX_CTRL_A, 32'h98);
      pause(3);
      chk({31'h0, done_irq}, 32'h0, "irq cleared");
      end_test("free run");
      wr(SAC_IDX_CTRL_B, 32'h40);
      pause(2);
      chk({31'h0, comp_neg_mux_sel}, 32'h0, "mux sel while on");
      wr(SAC_IDX_CTRL_A, 32'h00);
      pause(4);
      t0 = ticks;
      pause(20);
      chk({31'h0, comp_neg_mux_sel}, 32'h1, "mux sel while off");
      chk({29'h0, comp_mux_channel}, 32'h3, "mux channel");
      chk(32'(ticks - t0), 32'h0, "prescaler held");
      chk({31'h0, hresp}, 32'h0, "okay response");
      end_test("comparator");
      summarize();
   end
endmodule : tb
